// *** logic/adc_ctrl_defines.vh ***
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH
`define OFS_CTRL0        3'h0
`define OFS_CTRL1        3'h1
`define OFS_CTRL2        3'h2
`define OFS_RES_HIGH     3'h3
`define OFS_RES_LOW      3'h4
`define OFS_IRQ          3'h5
`define RST_CTRL         8'h00
`define RST_IRQ          8'h00
`define BIT_CAL          7
`define BIT_GO           1
`define BIT_ON           0
`define BIT_TRIG         7
`define BIT_NREF         5
`define BIT_PREF         4
`define BIT_JUSTIFY      7
`define BIT_DONE_FLAG    0
`define BIT_IRQ_EN       1
`define CONV_TAD         5'h0B
`define POST_WAIT_TAD    5'h02
`define RC_START_CYCLES  8'h04
`define RC_DIV_DEFAULT   80
`endif

// *** logic/sar_adc_control_logic.v ***
// sequencing and register logic for a 12-channel 12-bit successive-approximation converter
//
// Contract
// R1: convert the selected input into a 12-bit result; twelve selectable channels
// R2: calibrate_next set calibrates on the next conversion, clear converts normally
// R3: channel_select 0000..1011 picks channels 0..11, codes 11xx unused
// R4: with converter_on, convert_go_flag reads 1 while converting, 0 when idle
// R5: converter_on enables the module when 1, disables when 0
// R6: special_trigger_source picks charge_time_unit when 1, capture_compare_two when 0
// R7: neg_ref_source picks external negative reference on input 2, else analog ground
// R8: pos_ref_source picks external positive reference on input 3, else analog supply
// R9: pin_analog_config 0000-0011 all analog; each higher code makes one more digital
// R10: result_justify places result right-justified when 1, left-justified when 0
// R11: acquisition_time_sel sets acquisition 0,2,4,6,8,12,16,20 bit periods
// R12: conv_clock_sel picks osc /2,/8,/32,/4,/16,/64 or internal RC clock
// R13: internal RC clock starts one instruction cycle after conversion request
// R14: conversion in sleep works only with internal RC clock; software selects it
// R15: on completion load result, clear convert_go_flag, set conversion_done_flag
// R16: reset restores registers, switches module off, aborts any conversion
// R17: power-on reset leaves result pair unmodified
// R18: nonzero acquisition time samples after go, then converts by itself
// R19: software configures everything and waits acquisition when none programmed
// R20: software polls go flag or takes interrupt, reads result, clears done flag
// R21: at least two bit periods wait after a conversion before next acquisition
// R22: bit 6 of each control register reads zero
// R23: a full conversion takes eleven bit periods
// R24: clearing go flag aborts, keeps old result; acquisition restarts after wait
// R25: conversion_done_flag sticks until cleared; raises interrupt when enabled
//
// Our own choices: the plain strobed port and the placing of the registers.
`include "adc_ctrl_defines.vh"
module sar_adc_control_logic #(
   parameter RC_DIV = `RC_DIV_DEFAULT
) (
   input  wire        CLK,
   input  wire        RST_N,
   input  wire [2:0]  ADDR,
   input  wire [7:0]  WDATA,
   input  wire        WR,
   input  wire        RD,
   output reg  [7:0]  RDATA,
   input  wire        TRIG_CHARGE_TIME_UNIT,
   input  wire        TRIG_CAPTURE_COMPARE_TWO,
   input  wire        COMPARATOR,
   output reg  [3:0]  CHANNEL,
   output wire        SAMPLE,
   output reg  [11:0] DAC_CODE,
   output wire        CALIBRATE,
   output wire        NEG_REF_EXT,
   output wire        POS_REF_EXT,
   output wire [11:0] ANALOG_PINS,
   output wire        CONV_CLK_RC,
   output wire        IRQ
);
   localparam S_IDLE = 5'b00001;
   localparam S_START = 5'b00010;
   localparam S_ACQ = 5'b00100;
   localparam S_CONV = 5'b01000;
   localparam S_WAIT = 5'b10000;

   reg  [7:0]  ctrl0;
   reg  [7:0]  ctrl1;
   reg  [7:0]  ctrl2;
   reg  [11:0] result;
   reg         done_flag;
   reg         irq_en;
   reg  [4:0]  state;
   reg  [6:0]  div_cnt;
   reg  [4:0]  tad_cnt;
   reg  [7:0]  start_cnt;
   reg  [3:0]  bit_idx;
   reg         cal_pending;
   reg  [11:0] next_result;
   wire        tad_tick;
   wire        go_write;
   wire        go_clear;
   wire        finish;
   wire        rc_sel;
   wire [6:0]  div_len;
   wire [4:0]  acq_len;

   // oscillator cycles per bit period for each clock code
   function [6:0] tad_cycles;
      input [2:0] code;
      begin
         case (code)
            3'b000: tad_cycles = 7'h02;
            3'b001: tad_cycles = 7'h08;
            3'b010: tad_cycles = 7'h20;
            3'b100: tad_cycles = 7'h04;
            3'b101: tad_cycles = 7'h10;
            3'b110: tad_cycles = 7'h40;
            default: tad_cycles = RC_DIV[6:0];
         endcase
      end
   endfunction

   function [4:0] acq_tad;
      input [2:0] code;
      begin
         case (code)
            3'b111: acq_tad = 5'h14;
            3'b110: acq_tad = 5'h10;
            3'b101: acq_tad = 5'h0C;
            3'b100: acq_tad = 5'h08;
            3'b011: acq_tad = 5'h06;
            3'b010: acq_tad = 5'h04;
            3'b001: acq_tad = 5'h02;
            default: acq_tad = 5'h00;
         endcase
      end
   endfunction

   assign rc_sel = (ctrl2[1:0] == 2'b11);                                    // [R12] [R14]
   assign div_len = tad_cycles(ctrl2[2:0]);                                  // [R12]
   assign acq_len = acq_tad(ctrl2[5:3]);                                     // [R11]
   assign tad_tick = (div_cnt == div_len - 7'h01);
   assign go_write = WR && (ADDR == `OFS_CTRL0) && WDATA[`BIT_GO];
   assign go_clear = WR && (ADDR == `OFS_CTRL0) && !WDATA[`BIT_GO];
   assign finish = (state == S_CONV) && tad_tick && (tad_cnt == `CONV_TAD - 5'h01);

   assign SAMPLE = ctrl0[`BIT_ON] && (state != S_CONV) && (state != S_WAIT); // [R18] [R24]
   assign CALIBRATE = cal_pending && (state == S_CONV);                      // [R2]
   assign NEG_REF_EXT = ctrl1[`BIT_NREF];                                    // [R7]
   assign POS_REF_EXT = ctrl1[`BIT_PREF];                                    // [R8]
   assign CONV_CLK_RC = rc_sel;
   assign IRQ = done_flag && irq_en;                                         // [R25]

   // one pin per generate step; code 4 turns input 11 digital, code 15 all
   genvar g;
   generate
      for (g = 0; g < 12; g = g + 1) begin : pin_cfg
         assign ANALOG_PINS[g] = (ctrl1[3:0] < (15 - g));                   // [R9]
      end
   endgenerate

   // special trigger starts a conversion like a software go
   wire trig_sel = ctrl1[`BIT_TRIG] ? TRIG_CHARGE_TIME_UNIT : TRIG_CAPTURE_COMPARE_TWO; // [R6]
   wire start_req = ctrl0[`BIT_ON] && (state == S_IDLE) && (go_write || trig_sel);

   // comparator decides the trial bit; result built msb first
   always @* begin
      next_result = DAC_CODE;
      next_result[bit_idx] = COMPARATOR;
      // the last trial on bit 1 also settles bit 0
      if (bit_idx == 4'h1)
         next_result[0] = COMPARATOR;
   end

   always @(posedge CLK) begin
      if (!RST_N) begin
         ctrl0 <= `RST_CTRL;                                                 // [R16]
         ctrl1 <= `RST_CTRL;
         ctrl2 <= `RST_CTRL;
         done_flag <= 1'b0;
         irq_en <= 1'b0;
         state <= S_IDLE;
         div_cnt <= 7'h00;
         tad_cnt <= 5'h00;
         start_cnt <= 8'h00;
         bit_idx <= 4'hB;
         cal_pending <= 1'b0;
         DAC_CODE <= 12'h000;
         CHANNEL <= 4'h0;
      end else begin
         if (WR && ADDR == `OFS_CTRL0) begin
            ctrl0[7] <= WDATA[7];
            ctrl0[5:2] <= WDATA[5:2];
            ctrl0[`BIT_ON] <= WDATA[`BIT_ON];                                // [R5]
         end
         if (WR && ADDR == `OFS_CTRL1)
            ctrl1 <= {WDATA[7], 1'b0, WDATA[5:0]};                           // [R22]
         if (WR && ADDR == `OFS_CTRL2)
            ctrl2 <= {WDATA[7], 1'b0, WDATA[5:0]};
         if (WR && ADDR == `OFS_IRQ)
            irq_en <= WDATA[`BIT_IRQ_EN];
         // hardware set wins over a software clear in the same cycle
         if (finish)
            done_flag <= 1'b1;                                               // [R15] [R25]
         else if (WR && ADDR == `OFS_IRQ && !WDATA[`BIT_DONE_FLAG])
            done_flag <= 1'b0;                                               // [R20]
         if (ctrl0[5:4] != 2'b11)
            CHANNEL <= ctrl0[5:2];                                           // [R3]
         div_cnt <= (state == S_IDLE || tad_tick) ? 7'h00 : div_cnt + 7'h01;
         case (state)
            S_IDLE: begin
               if (start_req) begin
                  cal_pending <= ctrl0[`BIT_CAL];                            // [R2]
                  start_cnt <= 8'h00;
                  ctrl0[`BIT_GO] <= 1'b1;                                    // [R4]
                  state <= rc_sel ? S_START : S_ACQ;
               end
               tad_cnt <= 5'h00;
            end
            S_START: begin
               // the RC clock holds off one instruction cycle so sleep can enter first
               start_cnt <= start_cnt + 8'h01;
               div_cnt <= 7'h00;
               if (start_cnt == `RC_START_CYCLES - 8'h01)
                  state <= S_ACQ;                                            // [R13]
            end
            S_ACQ: begin
               if (acq_len == 5'h00 || (tad_tick && tad_cnt == acq_len - 5'h01)) begin
                  state <= S_CONV;                                           // [R18]
                  tad_cnt <= 5'h00;
                  bit_idx <= 4'hB;
                  DAC_CODE <= 12'h800;
               end else if (tad_tick)
                  tad_cnt <= tad_cnt + 5'h01;
            end
            S_CONV: begin
               if (tad_tick) begin
                  tad_cnt <= tad_cnt + 5'h01;
                  if (finish) begin
                     ctrl0[`BIT_GO] <= 1'b0;                                 // [R15]
                     cal_pending <= 1'b0;
                     state <= S_WAIT;
                     tad_cnt <= 5'h00;
                  end else begin
                     // one decision per bit period; the last period resolves two bits
                     DAC_CODE <= next_result | ((bit_idx > 4'h1) ? (12'h001 << (bit_idx - 4'h1)) : 12'h000);
                     if (bit_idx > 4'h1)
                        bit_idx <= bit_idx - 4'h1;                           // [R23]
                  end
               end
            end
            S_WAIT: begin
               if (tad_tick) begin
                  tad_cnt <= tad_cnt + 5'h01;
                  if (tad_cnt == `POST_WAIT_TAD - 5'h01)
                     state <= S_IDLE;                                        // [R21] [R24]
               end
            end
            default: state <= S_IDLE;
         endcase
         // software clear of go aborts without touching the result
         if ((go_clear || (WR && ADDR == `OFS_CTRL0 && !WDATA[`BIT_ON]))
             && (state == S_START || state == S_ACQ || state == S_CONV)) begin
            ctrl0[`BIT_GO] <= 1'b0;                                          // [R24]
            cal_pending <= 1'b0;
            state <= S_WAIT;
            tad_cnt <= 5'h00;
         end
      end
   end

   // result has no reset so power-on leaves it as found
   always @(posedge CLK) begin
      if (finish)
         result <= next_result;                                              // [R1] [R15]
      else if (WR && ADDR == `OFS_RES_HIGH)
         result[11:4] <= WDATA;                                              // [R17]
   end

   always @(posedge CLK) begin
      if (!RST_N)
         RDATA <= 8'h00;
      else if (RD) begin
         case (ADDR)
            `OFS_CTRL0: RDATA <= {ctrl0[7], 1'b0, ctrl0[5:0]};               // [R22] [R4]
            `OFS_CTRL1: RDATA <= ctrl1;
            `OFS_CTRL2: RDATA <= ctrl2;
            `OFS_RES_HIGH: RDATA <= ctrl2[`BIT_JUSTIFY] ? {4'h0, result[11:8]} : result[11:4]; // [R10]
            `OFS_RES_LOW: RDATA <= ctrl2[`BIT_JUSTIFY] ? result[7:0] : {result[3:0], 4'h0};    // [R10]
            `OFS_IRQ: RDATA <= {6'h00, irq_en, done_flag};
            default: RDATA <= 8'h00;
         endcase
      end else
         RDATA <= 8'h00;
   end
endmodule

// *** test/sar_adc_props_properties.sv ***
// port assertions for the converter control block
`include "adc_ctrl_defines.vh"
module sar_adc_props(
   input wire logic        CLK, RST_N, RD, WR, SAMPLE, IRQ, NEG_REF_EXT, POS_REF_EXT, CONV_CLK_RC,
   input wire logic [2:0]  ADDR,
   input wire logic [7:0]  RDATA,
   input wire logic [3:0]  CHANNEL,
   input wire logic [11:0] DAC_CODE, ANALOG_PINS
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   sequence rd_of(logic [2:0] a);
      RD && ADDR == a;
   endsequence
   function automatic logic [11:0] pins(input logic [3:0] c);
      return (c < 4'h4) ? 12'hFFF : 12'hFFF >> (c - 4'h3);
   endfunction
   a_gap_bit_zero: assert property (RD && ADDR <= 3'h2 |=> !RDATA[6])
      else $error("reserved bit read as one");
   a_ref_select: assert property (rd_of(`OFS_CTRL1) |=> NEG_REF_EXT == RDATA[5] && POS_REF_EXT == RDATA[4])
      else $error("reference select mismatch");
   a_pin_config: assert property (rd_of(`OFS_CTRL1) |=> ANALOG_PINS == pins(RDATA[3:0]))
      else $error("analog pin map mismatch");
   a_rc_select: assert property (rd_of(`OFS_CTRL2) |=> CONV_CLK_RC == (RDATA[1:0] == 2'h3))
      else $error("rc clock select mismatch");
   a_off_no_sample: assert property (rd_of(`OFS_CTRL0) ##1 !RDATA[0] |-> !SAMPLE)
      else $error("sampling while off");
   a_channel_route: assert property (rd_of(`OFS_CTRL0) ##1 RDATA[5:4] != 2'h3 |-> CHANNEL == RDATA[5:2])
      else $error("channel output mismatch");
   a_irq_level: assert property (rd_of(`OFS_IRQ) |=> $past(IRQ) == (RDATA[0] && RDATA[1]))
      else $error("irq not flag and enable");
   a_done_sticky: assert property (IRQ && !(WR && ADDR == `OFS_IRQ) |=> IRQ)
      else $error("done flag dropped alone");
   a_reset_clear: assert property (disable iff (1'b0) !RST_N |=> RDATA == 8'h00 && !IRQ && !SAMPLE && DAC_CODE == 12'h000)
      else $error("state not cleared by reset");
endmodule

// *** test/sar_adc_analog_model.sv ***
// behavioural comparator array: one level per channel against the trial code
module sar_adc_analog_model(
   input wire logic [3:0]  CHANNEL,
   input wire logic [11:0] DAC_CODE,
   output logic            COMPARATOR
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] level [12];
   assign COMPARATOR = level[CHANNEL] >= DAC_CODE;
endmodule

// *** test/sar_adc_control_logic_tb_top.sv ***
// self-checking bench for the converter control block
module sar_adc_control_logic_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        CLK = 1'b0, RST_N = 1'b0, WR = 1'b0, RD = 1'b0, TRIG = 1'b0, rd_d = 1'b0, cal_seen = 1'b0;
   logic        SAMPLE, CALIBRATE, NEG_REF_EXT, POS_REF_EXT, CONV_CLK_RC, IRQ, COMPARATOR;
   logic [2:0]  ADDR = 3'h0;
   logic [7:0]  WDATA = 8'h00, RDATA, rdv, pv;
   logic [3:0]  CHANNEL;
   logic [11:0] DAC_CODE, ANALOG_PINS, res;
   logic [18:0] q[$];
   logic [18:0] ent;
   int          n_errors = 0, cmp_count = 0;
   sar_adc_control_logic #(.RC_DIV(2)) dut_u(.CLK, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA,
      .TRIG_CHARGE_TIME_UNIT(TRIG), .TRIG_CAPTURE_COMPARE_TWO(TRIG), .COMPARATOR, .CHANNEL, .SAMPLE,
      .DAC_CODE, .CALIBRATE, .NEG_REF_EXT, .POS_REF_EXT, .ANALOG_PINS, .CONV_CLK_RC, .IRQ);
   sar_adc_analog_model model_u(.CHANNEL, .DAC_CODE, .COMPARATOR);
   initial forever #25 CLK = ~CLK;
   task automatic check(input string nm, input logic [7:0] e, input logic [7:0] s);
      cmp_count++;
      if (e !== s) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask
   // a zero mask notes a read left unchecked: a go-flag poll that steers the bench, or the unreset result
   task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      q.push_back({a, m, e});
      @(posedge CLK);
      RD <= 1'b0;
      @(posedge CLK);
      #1;
   endtask
   always @(posedge CLK) begin
      if (rd_d) begin
         ent = q.pop_front();
         rdv = RDATA;
         if (ent[15:8] != 8'h00) check($sformatf("reg %0d", ent[18:16]), ent[7:0] & ent[15:8], RDATA & ent[15:8]);
      end
      if (CALIBRATE === 1'b1) cal_seen <= 1'b1;
      rd_d <= RD;
   end
   task automatic conv(input logic [2:0] ck);
      logic [7:0]  c2;
      logic [3:0]  ch;
      logic [31:0] r;
      r = $urandom;
      c2 = {r[31], 1'b0, r[30:28], ck};
      ch = 4'(r[27:24] % 12);
      res = {r[11:2], {2{r[0]}}};
      model_u.level[ch] = res;
      wr(3'h2, c2);
      wr(3'h5, 8'h02);
      wr(3'h0, {r[23], 1'b0, ch, 2'h1});
      cal_seen = 1'b0;
      wr(3'h0, {r[23], 1'b0, ch, 2'h3});
      rd(3'h0, {1'b0, 1'b0, ch, 2'h3}, 8'h7F);
      for (int i = 0; i < 2000 && rdv[1] === 1'b1; i++) rd(3'h0, 8'h00, 8'h00);
      check("go clear", 8'h00, {7'h00, rdv[1]});
      rd(3'h5, 8'h03, 8'hFF);
      rd(3'h3, c2[7] ? {4'h0, res[11:8]} : res[11:4], 8'hFF);
      rd(3'h4, c2[7] ? res[7:0] : {res[3:0], 4'h0}, 8'hFF);
      check("calibrate", {7'h00, r[23]}, {7'h00, cal_seen});
      wr(3'h5, 8'h02);
      rd(3'h5, 8'h02, 8'hFF);
      repeat (140) @(posedge CLK);
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #3000000;
      n_errors++;
      close_out;
   end
   initial begin
      void'($urandom(10402));
      repeat (16) @(posedge CLK);
      RST_N <= 1'b1;
      for (int a = 0; a < 8; a++) rd(3'(a), 8'h00, (a == 3 || a == 4) ? 8'h00 : 8'hFF);
      wr(3'h1, 8'hFF);
      rd(3'h1, 8'hBF, 8'hFF);
      wr(3'h2, 8'hFF);
      rd(3'h2, 8'hBF, 8'hFF);
      $display("test registers done");
      for (int c = 0; c < 16; c++) begin
         pv = (8'($urandom) & 8'hB0) | 8'(c);
         wr(3'h1, pv);
         rd(3'h1, pv, 8'hFF);
      end
      $display("test pin map done");
      for (int k = 0; k < 8; k++) conv(3'(k));
      $display("test conversions done");
      model_u.level[0] = ~res;
      wr(3'h2, 8'h06);
      wr(3'h0, 8'h01);
      wr(3'h0, 8'h03);
      repeat (20) @(posedge CLK);
      wr(3'h0, 8'h01);
      rd(3'h0, 8'h01, 8'hFF);
      rd(3'h3, res[11:4], 8'hFF);
      rd(3'h4, {res[3:0], 4'h0}, 8'hFF);
      $display("test abort done");
      repeat (140) @(posedge CLK);
      wr(3'h0, 8'h03);
      repeat (5) @(posedge CLK);
      RST_N <= 1'b0;
      repeat (2) @(posedge CLK);
      RST_N <= 1'b1;
      rd(3'h0, 8'h00, 8'hFF);
      rd(3'h2, 8'h00, 8'hFF);
      $display("test reset abort done");
      close_out;
   end
endmodule
bind sar_adc_control_logic sar_adc_props chk_u(.CLK, .RST_N, .RD, .WR, .SAMPLE, .IRQ, .NEG_REF_EXT,
   .POS_REF_EXT, .CONV_CLK_RC, .ADDR, .RDATA, .CHANNEL, .DAC_CODE, .ANALOG_PINS);
